//--- core/dhrs_top.sv
// Purpose: Hardware reset sequencer of a display driver
// Assumes: hw_reset_in_n synchronous to sys_clk; 100 MHz clock
// Notes: Long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
module dhrs_top #(
  parameter int FILTER_CYC = dhrs_pkg::FILTER_CYC,
  parameter int LOAD_CYC = dhrs_pkg::LOAD_CYC,
  parameter int AWAKE_CYC = dhrs_pkg::AWAKE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hw_reset_in_n,
  input wire logic sleep_mode,
  input wire logic load_done,
  output var logic panel_blank,
  output var logic settings_default,
  output var logic load_req,
  output var logic cmd_ready,
  output var logic sleep_exit_ok,
  output var logic in_reset
);

  initial begin
    if (LOAD_CYC < 1 || AWAKE_CYC < LOAD_CYC) $error("Bad timing parameters");
  end

  localparam int TW = $clog2(AWAKE_CYC + 1);

  // ----------------------------------------------------------------
  // Spike filter
  // ----------------------------------------------------------------
  logic filt_n;

  dhrs_spike_filter #(
    .WIDTH(FILTER_CYC)
  ) u_filter (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_n(hw_reset_in_n),
    .level_n(filt_n)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  dhrs_pkg::dhrs_state_t state_r, state_nxt;
  dhrs_pkg::dhrs_status_t st_r, st_nxt;
  logic [TW-1:0] tmr_r, tmr_nxt;
  logic [TW-1:0] since_r, since_nxt;
  logic awake_r, awake_nxt;
  logic inrst_r, inrst_nxt;

  // Next state and outputs
  always_comb begin
    state_nxt = state_r;
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    since_nxt = since_r;
    awake_nxt = awake_r;
    inrst_nxt = inrst_r;
    st_nxt.load_req = 1'b0;
    // Time since release gates host commands
    if (!inrst_r && since_r != TW'(AWAKE_CYC)) begin
      since_nxt = since_r + 1'b1;
    end
    st_nxt.cmd_ready = !inrst_r && (since_r >= TW'(LOAD_CYC)) && state_r == dhrs_pkg::DHRS_IDLE;
    st_nxt.sleep_exit_ok = st_nxt.cmd_ready && (since_r >= TW'(AWAKE_CYC));
    case (state_r)
      dhrs_pkg::DHRS_IDLE: begin
        if (!filt_n) begin
          // (R5) Blank panel on reset
          st_nxt.panel_blank = 1'b1;
          st_nxt.cmd_ready = 1'b0;
          st_nxt.sleep_exit_ok = 1'b0;
          inrst_nxt = 1'b1;
          awake_nxt = !sleep_mode;
          tmr_nxt = '0;
          // (R6) Blanking sequence when awake
          state_nxt = sleep_mode ? dhrs_pkg::DHRS_HELD : dhrs_pkg::DHRS_BLANK_SEQ;
        end
      end
      dhrs_pkg::DHRS_BLANK_SEQ: begin
        // (R6) Bounded blanking run
        tmr_nxt = tmr_r + 1'b1;
        if (tmr_r == TW'(AWAKE_CYC - 1)) begin
          state_nxt = dhrs_pkg::DHRS_HELD;
        end
      end
      dhrs_pkg::DHRS_HELD: begin
        // (R5) Settings to defaults
        st_nxt.settings_default = 1'b1;
        if (filt_n) begin
          // (R3) Start reload on release
          st_nxt.load_req = 1'b1;
          inrst_nxt = 1'b0;
          since_nxt = '0;
          tmr_nxt = '0;
          state_nxt = dhrs_pkg::DHRS_LOAD;
        end
      end
      dhrs_pkg::DHRS_LOAD: begin
        tmr_nxt = tmr_r + 1'b1;
        // (R3) Reload bounded by 5 ms
        if (load_done || tmr_r == TW'(LOAD_CYC - 1)) begin
          st_nxt.settings_default = 1'b0;
          state_nxt = dhrs_pkg::DHRS_SETTLE;
        end
      end
      dhrs_pkg::DHRS_SETTLE: begin
        tmr_nxt = tmr_r + 1'b1;
        // (R4) Release time by prior mode
        if (tmr_r >= TW'((awake_r ? AWAKE_CYC : LOAD_CYC) - 1)) begin
          st_nxt.panel_blank = sleep_mode;
          state_nxt = dhrs_pkg::DHRS_IDLE;
        end
      end
      default: begin
        state_nxt = dhrs_pkg::DHRS_IDLE;
      end
    endcase
    // (R2) Reassertion after release restarts reset
    if (!filt_n && state_r != dhrs_pkg::DHRS_IDLE && !inrst_r) begin
      st_nxt.panel_blank = 1'b1;
      st_nxt.load_req = 1'b0;
      inrst_nxt = 1'b1;
      tmr_nxt = '0;
      state_nxt = dhrs_pkg::DHRS_HELD;
    end
  end

  // Registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= dhrs_pkg::DHRS_IDLE;
      st_r <= dhrs_pkg::STATUS_RESET;
      tmr_r <= '0;
      since_r <= '0;
      awake_r <= 1'b0;
      inrst_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      since_r <= since_nxt;
      awake_r <= awake_nxt;
      inrst_r <= inrst_nxt;
    end
  end

  assign panel_blank = st_r.panel_blank;
  assign settings_default = st_r.settings_default;
  assign load_req = st_r.load_req;
  assign cmd_ready = st_r.cmd_ready;
  assign sleep_exit_ok = st_r.sleep_exit_ok;
  assign in_reset = inrst_r;

endmodule
`default_nettype wire

//--- core/dhrs_pkg.sv
// Purpose: Shared constants and types for the display hardware reset sequencer
// Assumes: 100 MHz system clock, reset pin synchronous to it
// Notes: Timing figures are kept in their own units and converted to cycles here
//
// Functional notes
// (R1) Reset pin lows under 5us are ignored; lows over 9us always reset.
// (R2) Brief high glitches inside a valid low reset are filtered the same way.
// (R3) Every reset release reloads identity, electrode level and settings within 5 ms; a release during awake blanking reloads only once it ends.
// (R4) Release processing ends within 5 ms from sleep, 120 ms from awake; code times it from leaving DHRS_HELD, after any blanking sequence.
// (R5) Panel is blanked during reset, then settings return to defaults.
// (R6) Awake reset runs a blanking sequence of at most 120 ms; sleep stays blank. Code skips the sequence on a reassertion during release processing.
// (R7) Host waits at least 5 ms after release before any command.
// (R8) Host waits at least 120 ms after release before sleep exit.
// (R9) Host holds reset low about ten microseconds or more.
package dhrs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int REJECT_US = 5;
  localparam int ACCEPT_US = 9;
  localparam int LOAD_MS = 5;
  localparam int AWAKE_MS = 120;
  // Filter threshold sits between the bounds: at 7us a low is accepted
  localparam int FILTER_US = (REJECT_US + ACCEPT_US) / 2;
  localparam int FILTER_CYC = FILTER_US * CLK_MHZ;
  localparam int LOAD_CYC = LOAD_MS * 1000 * CLK_MHZ;
  localparam int AWAKE_CYC = AWAKE_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DHRS_IDLE,
    DHRS_BLANK_SEQ,
    DHRS_HELD,
    DHRS_LOAD,
    DHRS_SETTLE
  } dhrs_state_t;

  // Status presented to the rest of the device
  typedef struct packed {
    logic panel_blank;
    logic settings_default;
    logic load_req;
    logic cmd_ready;
    logic sleep_exit_ok;
  } dhrs_status_t;

  localparam dhrs_status_t STATUS_RESET = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

endpackage

//--- core/dhrs_spike_filter.sv
// Purpose: Symmetric spike filter on the reset pin
// Assumes: Input synchronous to sys_clk
// Notes: Output changes only after the input holds a new level for WIDTH cycles
`timescale 1ns/1ps
`default_nettype none
module dhrs_spike_filter #(
  parameter int WIDTH = 700
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pin_n,
  output var logic level_n
);

  initial begin
    if (WIDTH < 2) $error("WIDTH too small");
  end

  localparam int CW = $clog2(WIDTH + 1);
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic level_r, level_nxt;

  // (R1) Count cycles the pin differs from the output
  // (R2) Same filter for high glitches
  always_comb begin
    cnt_nxt = cnt_r;
    level_nxt = level_r;
    if (pin_n == level_r) begin
      cnt_nxt = '0;
    end else if (cnt_r == CW'(WIDTH - 1)) begin
      cnt_nxt = '0;
      level_nxt = pin_n;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  // State registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      level_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      level_r <= level_nxt;
    end
  end

  assign level_n = level_r;

endmodule
`default_nettype wire

//--- sim/dhrs_host_model.sv
// Purpose: Host pin driver and storage loader
// Assumes: Calls start just after a rising edge
// Notes: Loader answers a reload 3 cycles late
`timescale 1ns/1ps
`default_nettype none
module dhrs_host_model (
  input wire logic sys_clk,
  input wire logic load_req,
  output var logic hw_reset_in_n,
  output var logic load_done
);
  initial begin
    hw_reset_in_n = 1'b1;
    load_done = 1'b0;
  end
  task automatic hold(input logic lvl, input int n);
    hw_reset_in_n = lvl;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Reload answer pulse
  always @(posedge sys_clk) begin
    if (load_req === 1'b1) begin
      repeat (3) @(posedge sys_clk);
      #1 load_done = 1'b1;
      @(posedge sys_clk) #1 load_done = 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- sim/dhrs_top_sva.sv
// Purpose: Port checks of the reset sequencer
// Assumes: Pin synchronous to sys_clk
// Notes: Release bounds follow the dut parameters; pin run figures 5 and 9 are fixed
`timescale 1ns/1ps
`default_nettype none
module dhrs_top_sva #(
  parameter int FILTER_CYC = 8,
  parameter int LOAD_CYC = 50,
  parameter int AWAKE_CYC = 200
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hw_reset_in_n,
  input wire logic sleep_mode,
  input wire logic panel_blank,
  input wire logic settings_default,
  input wire logic load_req,
  input wire logic cmd_ready,
  input wire logic sleep_exit_ok,
  input wire logic in_reset
);
  localparam int LD_LIM = LOAD_CYC + 4;
  localparam int AW_LIM = AWAKE_CYC + 4;
  logic [3:0] lo_r, lo_nxt, hi_r, hi_nxt;
  logic [15:0] since_r, since_nxt;
  logic [15:0] rc_r, rc_nxt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Run lengths and cycles since release
  always_comb begin
    lo_nxt = hw_reset_in_n ? 4'h0 : lo_r + {3'h0, lo_r != 4'hF};
    hi_nxt = !hw_reset_in_n ? 4'h0 : hi_r + {3'h0, hi_r != 4'hF};
    since_nxt = in_reset ? 16'h0 : since_r + {15'h0, since_r != 16'hFFFF};
    // Cycles spent in reset, saturating
    rc_nxt = in_reset ? rc_r + {15'h0, rc_r != 16'hFFFF} : 16'h0;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_r <= 4'h0;
      hi_r <= 4'h0;
      since_r <= 16'hFFFF;
      rc_r <= 16'h0;
    end else begin
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      since_r <= since_nxt;
      rc_r <= rc_nxt;
    end
  end
  // Ten lows in a row: nine counted plus the current sample
  sequence s_long_low;
    !hw_reset_in_n && lo_r >= 4'h9;
  endsequence
  sequence s_pulse;
    load_req ##1 !load_req;
  endsequence
  AST_LOW_TAKEN: assert property (s_long_low |-> ##[0:2] in_reset)
    else $error("long low not taken");
  AST_SPIKE_IGNORED: assert property (!in_reset && $rose(hw_reset_in_n) && lo_r < 4'h5
    |-> !in_reset [*4]) else $error("spike taken");
  AST_GLITCH_HELD: assert property (in_reset && $fell(hw_reset_in_n) && hi_r < 4'h5
    |-> in_reset [*4]) else $error("glitch ended reset");
  AST_BLANK: assert property (in_reset |-> panel_blank)
    else $error("not blank in reset");
  AST_DEFAULTS: assert property (in_reset && rc_r >= 16'(AW_LIM) |-> settings_default)
    else $error("settings not default after blanking");
  AST_LOAD_PULSE: assert property ($fell(in_reset) |-> s_pulse)
    else $error("no reload pulse");
  AST_RELOAD_END: assert property ($fell(in_reset) |-> ##[0:LD_LIM] !settings_default)
    else $error("reload late");
  AST_CMD_WAIT: assert property (cmd_ready |-> since_r + FILTER_CYC >= LOAD_CYC)
    else $error("commands too early");
  AST_EXIT_WAIT: assert property (sleep_exit_ok |-> since_r + FILTER_CYC >= AWAKE_CYC)
    else $error("sleep exit too early");
  AST_SLEEP_DONE: assert property ($fell(in_reset) && sleep_mode |-> ##[1:LD_LIM] cmd_ready)
    else $error("sleep release late");
  AST_AWAKE_DONE: assert property ($fell(in_reset) |-> ##[1:AW_LIM] sleep_exit_ok)
    else $error("awake release late");
endmodule
bind dhrs_top dhrs_top_sva #(.FILTER_CYC(FILTER_CYC), .LOAD_CYC(LOAD_CYC),
  .AWAKE_CYC(AWAKE_CYC)) u_sva (.sys_clk(sys_clk), .rst_n(rst_n),
  .hw_reset_in_n(hw_reset_in_n), .sleep_mode(sleep_mode), .panel_blank(panel_blank),
  .settings_default(settings_default), .load_req(load_req), .cmd_ready(cmd_ready),
  .sleep_exit_ok(sleep_exit_ok), .in_reset(in_reset));
`default_nettype wire

//--- sim/testbench.sv
// Purpose: Self-checking bench of the reset sequencer
// Assumes: Short counts 8, 50 and 200 cycles
// Notes: Host model drives the pin
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk, rst_n, sleep_mode;
  logic panel_blank, settings_default, load_req, cmd_ready, sleep_exit_ok, in_reset;
  wire logic hw_reset_in_n, load_done;
  int fails = 0, checks = 0;
  dhrs_top #(.FILTER_CYC(8), .LOAD_CYC(50), .AWAKE_CYC(200)) dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .hw_reset_in_n(hw_reset_in_n), .sleep_mode(sleep_mode),
    .load_done(load_done), .panel_blank(panel_blank), .settings_default(settings_default),
    .load_req(load_req), .cmd_ready(cmd_ready), .sleep_exit_ok(sleep_exit_ok),
    .in_reset(in_reset));
  dhrs_host_model host (.sys_clk(sys_clk), .load_req(load_req),
    .hw_reset_in_n(hw_reset_in_n), .load_done(load_done));
  // Compare and report
  task automatic check(input string what, input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("Counts: %0d checks, %0d fails", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Short low must be ignored
  task automatic t_spike;
    host.hold(1'b0, 3);
    host.hold(1'b1, 12);
    check("spike in_reset", in_reset, 1'b0);
    $display("Test spike done");
  endtask
  // Reset with a high glitch, then release timing
  task automatic t_reset(input string name, input logic slp, input int low);
    int i, t_cmd;
    sleep_mode = slp;
    t_cmd = 0;
    host.hold(1'b0, 12);
    check("in_reset taken", in_reset, 1'b1);
    host.hold(1'b1, 3);
    host.hold(1'b0, low);
    check("in_reset glitch", in_reset, 1'b1);
    check("blank in reset", panel_blank, 1'b1);
    check("defaults in reset", settings_default, 1'b1);
    host.hold(1'b1, 1);
    for (i = 1; i < 400 && sleep_exit_ok !== 1'b1; i++) begin
      if (cmd_ready !== 1'b1) t_cmd = i;
      host.hold(1'b1, 1);
    end
    check("cmd wait", t_cmd >= 50, 1'b1);
    check("cmd bound", t_cmd <= (slp ? 62 : 212), 1'b1);
    check("exit wait", i >= 200, 1'b1);
    check("exit bound", i <= 212, 1'b1);
    host.hold(1'b1, 3);
    check("reloaded", settings_default, 1'b0);
    check("blank after", panel_blank, slp);
    $display("Test %s done", name);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    rst_n = 1'b0;
    sleep_mode = 1'b1;
    repeat (20) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    host.hold(1'b1, 2);
    t_spike();
    t_reset("sleep", 1'b1, 20);
    t_reset("awake", 1'b0, 250);
    end_of_test();
  end
  // Watchdog
  initial begin
    #30000;
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
